/* verilog/fp_status_fields_recip_approx.sv */
`timescale 1ns/1ps
module fp_status_fields_recip_approx #(
   parameter int EST_BITS = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire fp_rcp_pkg::apb_req_t apb_req,
   output fp_rcp_pkg::apb_rsp_t apb_rsp,
   output logic irq
);

   ////////////////////////////////////////////////////////////////////////////////
   // bus slave
   logic acc_first;
   logic acc_done;
   logic wr;
   logic rd;
   logic hit;
   logic ro;
   logic [31:0] rdata;
   logic [2:0] rd_snap;

   fp_rcp_pkg::fp_reg_t op_a;
   fp_rcp_pkg::fp_reg_t op_b;
   fp_rcp_pkg::fp_reg_t result;
   fp_rcp_pkg::field_t fld [fp_rcp_pkg::FIELDS];
   fp_rcp_pkg::field_t sw_data [fp_rcp_pkg::FIELDS];
   logic [fp_rcp_pkg::FIELDS-1:0] sw_we;
   logic [fp_rcp_pkg::FIELDS-1:0] clr;
   logic [5:0] set_flags [fp_rcp_pkg::FIELDS];
   logic pred;
   logic fault_st;
   logic [2:0] istat;
   logic [2:0] imask;
   logic [2:0] events;

   logic go;
   fp_rcp_pkg::op_t go_op;
   logic [1:0] go_sf;
   logic [1:0] go_prec;
   logic [1:0] go_ld;
   logic [1:0] go_src;

   assign acc_first = apb_req.psel && apb_req.penable && !apb_rsp.pready;
   assign acc_done = apb_req.psel && apb_req.penable && apb_rsp.pready;
   assign wr = acc_done && apb_req.pwrite;
   assign rd = acc_done && !apb_req.pwrite;

   always_comb begin
      rdata = 32'h0;
      hit = 1'b1;
      ro = 1'b0;
      case (apb_req.paddr)
         fp_rcp_pkg::CTRL_OFS: rdata = {22'h0, go_src, go_ld, go_prec, go_sf, go_op};
         fp_rcp_pkg::FP_STATUS_REGISTER_LO_OFS: rdata = {8'h0, fld[1], fld[0]};
         fp_rcp_pkg::FP_STATUS_REGISTER_HI_OFS: rdata = {8'h0, fld[3], fld[2]};
         fp_rcp_pkg::OPA_OFS: rdata = op_a.sig[31:0];
         fp_rcp_pkg::OPA_OFS + 8'h04: rdata = op_a.sig[63:32];
         fp_rcp_pkg::OPA_OFS + 8'h08: rdata = {14'h0, op_a.sign, op_a.exp};
         fp_rcp_pkg::OPB_OFS: rdata = op_b.sig[31:0];
         fp_rcp_pkg::OPB_OFS + 8'h04: rdata = op_b.sig[63:32];
         fp_rcp_pkg::OPB_OFS + 8'h08: rdata = {14'h0, op_b.sign, op_b.exp};
         fp_rcp_pkg::RES_OFS: begin
            rdata = result.sig[31:0];
            ro = 1'b1;
         end
         fp_rcp_pkg::RES_OFS + 8'h04: begin
            rdata = result.sig[63:32];
            ro = 1'b1;
         end
         fp_rcp_pkg::RES_OFS + 8'h08: begin
            rdata = {14'h0, result.sign, result.exp};
            ro = 1'b1;
         end
         fp_rcp_pkg::RSTATE_OFS: begin
            rdata = {29'h0, go, fault_st, pred};
            ro = 1'b1;
         end
         fp_rcp_pkg::ISTAT_OFS: begin
            rdata = {29'h0, istat};
            ro = 1'b1;
         end
         fp_rcp_pkg::IMASK_OFS: rdata = {29'h0, imask};
         default: hit = 1'b0;
      endcase
   end

   // answer in the second access cycle; read data taken one edge early
   always_ff @(posedge clk) begin
      if (rst) begin
         apb_rsp <= '0;
         rd_snap <= 3'h0;
      end else begin
         apb_rsp.pready <= acc_first;
         if (acc_first) begin
            apb_rsp.prdata <= apb_req.pwrite ? 32'h0 : rdata;
            apb_rsp.pslverr <= !hit || (apb_req.pwrite && ro);
            rd_snap <= (!apb_req.pwrite && apb_req.paddr == fp_rcp_pkg::ISTAT_OFS) ?
               istat : 3'h0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // operand registers and launch
   logic wr_ok;
   assign wr_ok = wr && hit && !ro;

   always_ff @(posedge clk) begin
      if (rst) begin
         op_a <= '0;
         op_b <= '0;
         imask <= 3'h0;
      end else if (wr_ok) begin
         case (apb_req.paddr)
            fp_rcp_pkg::OPA_OFS: op_a.sig[31:0] <= apb_req.pwdata;
            fp_rcp_pkg::OPA_OFS + 8'h04: op_a.sig[63:32] <= apb_req.pwdata;
            fp_rcp_pkg::OPA_OFS + 8'h08: {op_a.sign, op_a.exp} <= apb_req.pwdata[17:0];
            fp_rcp_pkg::OPB_OFS: op_b.sig[31:0] <= apb_req.pwdata;
            fp_rcp_pkg::OPB_OFS + 8'h04: op_b.sig[63:32] <= apb_req.pwdata;
            fp_rcp_pkg::OPB_OFS + 8'h08: {op_b.sign, op_b.exp} <= apb_req.pwdata[17:0];
            fp_rcp_pkg::IMASK_OFS: imask <= apb_req.pwdata[2:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         go <= 1'b0;
         go_op <= fp_rcp_pkg::OP_RECIP;
         go_sf <= 2'h0;
         go_prec <= 2'h0;
         go_ld <= 2'h0;
         go_src <= 2'h0;
      end else begin
         go <= wr_ok && apb_req.paddr == fp_rcp_pkg::CTRL_OFS;
         if (wr_ok && apb_req.paddr == fp_rcp_pkg::CTRL_OFS) begin
            go_op <= fp_rcp_pkg::op_t'(apb_req.pwdata[fp_rcp_pkg::CTRL_OP_LSB +: 2]);
            go_sf <= apb_req.pwdata[fp_rcp_pkg::CTRL_SF_LSB +: 2];
            go_prec <= apb_req.pwdata[fp_rcp_pkg::CTRL_PREC_LSB +: 2];
            go_ld <= apb_req.pwdata[fp_rcp_pkg::CTRL_LD_LSB +: 2];
            go_src <= apb_req.pwdata[fp_rcp_pkg::CTRL_SRC_LSB +: 2];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // reciprocal step and result shaping
   logic rc_valid;
   fp_rcp_pkg::fp_reg_t rc_result;
   logic rc_pred;
   logic [2:0] rc_flags;
   logic rc_fault;

   fp_recip_est #(.EST_BITS(EST_BITS)) u_est (
      .clk(clk),
      .rst(rst),
      .start(go && go_op == fp_rcp_pkg::OP_RECIP),
      .op_a(op_a),
      .op_b(op_b),
      .valid(rc_valid),
      .result(rc_result),
      .pred(rc_pred),
      .flags(rc_flags),
      .fault(rc_fault)
   );

   fp_rcp_pkg::field_t sel;
   logic [63:0] pmask;
   logic [16:0] lim;
   logic [17:0] uexp;
   logic ovf;
   logic unf;
   logic finite_nz;

   // only truncation is applied; rounding control is kept for software to read
   always_comb begin
      sel = fld[go_sf];
      if (go_prec == fp_rcp_pkg::PREC_SINGLE ||
          (go_prec > fp_rcp_pkg::PREC_DOUBLE &&
           sel.precision_control_field == fp_rcp_pkg::PC_SINGLE)) begin
         pmask = fp_rcp_pkg::SGL_MASK;
         lim = fp_rcp_pkg::SGL_BIAS;
      end else if (go_prec == fp_rcp_pkg::PREC_DOUBLE ||
                   sel.precision_control_field == fp_rcp_pkg::PC_DOUBLE) begin
         pmask = fp_rcp_pkg::DBL_MASK;
         lim = fp_rcp_pkg::DBL_BIAS;
      end else begin
         pmask = 64'hffff_ffff_ffff_ffff;
         lim = fp_rcp_pkg::EXT_BIAS;
      end
      if (sel.wide_exponent_bit) begin
         lim = fp_rcp_pkg::WIDE_LIM;
      end
      uexp = {1'b0, rc_result.exp} - {1'b0, fp_rcp_pkg::BIAS};
      finite_nz = rc_result.exp != fp_rcp_pkg::EXP_MAX && rc_result.exp != 17'h00000;
      ovf = finite_nz && !uexp[17] && uexp[16:0] > lim;
      unf = finite_nz && uexp[17] && (18'h0 - uexp) >= {1'b0, lim};
   end

   function automatic fp_rcp_pkg::fp_reg_t load_conv(logic [1:0] ty, fp_rcp_pkg::fp_reg_t s);
      fp_rcp_pkg::fp_reg_t r;
      r = '0;
      if (ty == fp_rcp_pkg::LD_SINGLE) begin
         r.sign = s.sig[31];
         r.sig = {s.sig[30:23] != 8'h00, s.sig[22:0], 40'h0};
         if (s.sig[30:23] == 8'hff) r.exp = fp_rcp_pkg::EXP_MAX;
         else if (s.sig[30:0] == 31'h0) r.exp = 17'h00000;
         else if (s.sig[30:23] == 8'h00) r.exp = fp_rcp_pkg::BIAS - fp_rcp_pkg::SGL_BIAS + 17'h1;
         else r.exp = fp_rcp_pkg::BIAS - fp_rcp_pkg::SGL_BIAS + {9'h0, s.sig[30:23]};
      end else if (ty == fp_rcp_pkg::LD_DOUBLE) begin
         r.sign = s.sig[63];
         r.sig = {s.sig[62:52] != 11'h000, s.sig[51:0], 11'h0};
         if (s.sig[62:52] == 11'h7ff) r.exp = fp_rcp_pkg::EXP_MAX;
         else if (s.sig[62:0] == 63'h0) r.exp = 17'h00000;
         else if (s.sig[62:52] == 11'h000) r.exp = fp_rcp_pkg::BIAS - fp_rcp_pkg::DBL_BIAS + 17'h1;
         else r.exp = fp_rcp_pkg::BIAS - fp_rcp_pkg::DBL_BIAS + {6'h0, s.sig[62:52]};
      end else begin
         r.sign = s.exp[15];
         r.sig = s.sig;
         if (s.exp[14:0] == 15'h7fff) r.exp = fp_rcp_pkg::EXP_MAX;
         else if (s.exp[14:0] == 15'h0 && s.sig == 64'h0) r.exp = 17'h00000;
         else if (s.exp[14:0] == 15'h0) r.exp = fp_rcp_pkg::BIAS - fp_rcp_pkg::EXT_BIAS + 17'h1;
         else r.exp = fp_rcp_pkg::BIAS - fp_rcp_pkg::EXT_BIAS + {2'h0, s.exp[14:0]};
      end
      return r;
   endfunction : load_conv

   always_ff @(posedge clk) begin
      if (rst) begin
         result <= '0;
         pred <= 1'b0;
         fault_st <= 1'b0;
      end else if (go && go_op == fp_rcp_pkg::OP_LOAD) begin
         result <= load_conv(go_ld, op_a);
      end else if (rc_valid) begin
         result <= '{rc_result.sign, rc_result.exp, rc_result.sig & pmask};
         pred <= rc_pred;
         fault_st <= rc_fault;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // status fields; recip and discard touch only the field picked by go_sf, commit clears field go_src and sets its flags in field 0
   always_comb begin
      for (int i = 0; i < fp_rcp_pkg::FIELDS; i++) begin
         set_flags[i] = 6'h00;
         clr[i] = 1'b0;
         sw_we[i] = wr_ok && (apb_req.paddr == (i < 2 ? fp_rcp_pkg::FP_STATUS_REGISTER_LO_OFS :
            fp_rcp_pkg::FP_STATUS_REGISTER_HI_OFS));
         sw_data[i] = apb_req.pwdata[(i % 2) * fp_rcp_pkg::FIELD_W +: fp_rcp_pkg::FIELD_W];
      end
      if (rc_valid) begin
         set_flags[go_sf] = {1'b0, unf, ovf, rc_flags};
      end
      if (go && go_op == fp_rcp_pkg::OP_COMMIT && go_src != 2'h0) begin
         set_flags[0] = fld[go_src].flags;
         clr[go_src] = 1'b1;
      end
      if (go && go_op == fp_rcp_pkg::OP_DISCARD) begin
         clr[go_sf] = 1'b1;
      end
   end

   for (genvar g = 0; g < fp_rcp_pkg::FIELDS; g++) begin : g_fld
      fp_status_field u_fld (
         .clk(clk),
         .rst(rst),
         .sw_we(sw_we[g]),
         .sw_data(sw_data[g]),
         .set_flags(set_flags[g]),
         .clr(clr[g]),
         .field(fld[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////////////
   // interrupts; read clears only what the read returned, so a new event survives
   assign events[fp_rcp_pkg::IRQ_DONE] = rc_valid || (go && go_op != fp_rcp_pkg::OP_RECIP);
   assign events[fp_rcp_pkg::IRQ_ASSIST] = rc_valid && rc_fault;
   assign events[fp_rcp_pkg::IRQ_TRAP] = rc_valid && !sel.td && (rc_flags != 3'h0);

   always_ff @(posedge clk) begin
      if (rst) begin
         istat <= 3'h0;
         irq <= 1'b0;
      end else begin
         istat <= (rd ? istat & ~rd_snap : istat) | events;
         irq <= (istat & imask) != 3'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence s_recip_launch;
      go && go_op == fp_rcp_pkg::OP_RECIP;
   endsequence

   property p_apb_answer;
      acc_first |=> apb_rsp.pready ##1 !apb_rsp.pready;
   endproperty
   a_apb_answer: assert property (p_apb_answer) else $error("apb answer late");

   property p_est_scale;
      rc_valid && rc_pred |-> ({1'b0, rc_result.exp} + {1'b0, op_b.exp} == fp_rcp_pkg::TWO_BIAS ||
         {1'b0, rc_result.exp} + {1'b0, op_b.exp} + 18'h1 == fp_rcp_pkg::TWO_BIAS) &&
         rc_result.sig[63];
   endproperty
   a_est_scale: assert property (p_est_scale) else $error("estimate exponent wrong");

   property p_special_zero_div;
      s_recip_launch ##0 (op_b.exp == 17'h0 && op_b.sig == 64'h0 && op_a.sig[63] &&
         op_a.exp != fp_rcp_pkg::EXP_MAX) |=> !rc_pred && rc_flags[fp_rcp_pkg::FLAG_Z] &&
         rc_result.exp == fp_rcp_pkg::EXP_MAX;
   endproperty
   a_special_zero_div: assert property (p_special_zero_div) else $error("x/0 wrong");

   property p_assist;
      rc_valid && rc_fault |-> !rc_pred ##1 istat[fp_rcp_pkg::IRQ_ASSIST] && fault_st;
   endproperty
   a_assist: assert property (p_assist) else $error("assist fault lost");

   property p_main_untouched;
      rc_valid && go_sf != 2'h0 && !sw_we[0] |=> fld[0].flags == $past(fld[0].flags);
   endproperty
   a_main_untouched: assert property (p_main_untouched) else $error("main field hit");

   property p_sticky;
      !sw_we[0] && !clr[0] |=> (($past(fld[0].flags) & ~fld[0].flags) == 6'h00);
   endproperty
   a_sticky: assert property (p_sticky) else $error("flag dropped");

   sequence s_commit;
      go && go_op == fp_rcp_pkg::OP_COMMIT && go_src != 2'h0 && !sw_we[0];
   endsequence

   property p_commit;
      s_commit |=> ((fld[0].flags & $past(fld[go_src].flags)) == $past(fld[go_src].flags));
   endproperty
   a_commit: assert property (p_commit) else $error("commit lost flags");

   property p_load_single_one;
      go && go_op == fp_rcp_pkg::OP_LOAD && go_ld == fp_rcp_pkg::LD_SINGLE &&
         op_a.sig[31:0] == 32'h3f80_0000 |=> result.exp == fp_rcp_pkg::BIAS &&
         result.sig == fp_rcp_pkg::ONE_SIG && !result.sign;
   endproperty
   a_load_single_one: assert property (p_load_single_one) else $error("load wrong");

   property p_irq;
      ##1 irq == ($past((istat & imask)) != 3'h0);
   endproperty
   a_irq: assert property (p_irq) else $error("irq mismatch");

endmodule : fp_status_fields_recip_approx

/* pkg/fp_rcp_pkg.sv */
package fp_rcp_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // register map, byte addresses of 32-bit words
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] FP_STATUS_REGISTER_LO_OFS = 8'h04;
   localparam logic [7:0] FP_STATUS_REGISTER_HI_OFS = 8'h08;
   localparam logic [7:0] OPA_OFS = 8'h0c;
   localparam logic [7:0] OPB_OFS = 8'h18;
   localparam logic [7:0] RES_OFS = 8'h24;
   localparam logic [7:0] RSTATE_OFS = 8'h30;
   localparam logic [7:0] ISTAT_OFS = 8'h34;
   localparam logic [7:0] IMASK_OFS = 8'h38;

   // control word fields
   localparam int CTRL_OP_LSB = 0;
   localparam int CTRL_SF_LSB = 2;
   localparam int CTRL_PREC_LSB = 4;
   localparam int CTRL_LD_LSB = 6;
   localparam int CTRL_SRC_LSB = 8;
   localparam int FIELD_W = 12;
   localparam int FIELDS = 4;

   typedef enum logic [1:0] {OP_RECIP, OP_LOAD, OP_COMMIT, OP_DISCARD} op_t;

   localparam logic [1:0] PREC_SINGLE = 2'h0;
   localparam logic [1:0] PREC_DOUBLE = 2'h1;
   localparam logic [1:0] PC_SINGLE = 2'h0;
   localparam logic [1:0] PC_DOUBLE = 2'h2;
   localparam logic [1:0] LD_SINGLE = 2'h0;
   localparam logic [1:0] LD_DOUBLE = 2'h1;

   // flag positions inside a status field
   localparam int FLAG_V = 0;
   localparam int FLAG_D = 1;
   localparam int FLAG_Z = 2;
   localparam int FLAG_O = 3;
   localparam int FLAG_U = 4;

   // interrupt status bits
   localparam int IRQ_DONE = 0;
   localparam int IRQ_ASSIST = 1;
   localparam int IRQ_TRAP = 2;

   ////////////////////////////////////////////////////////////////////////////////
   // register-file number format
   typedef struct packed {
      logic sign;
      logic [16:0] exp;
      logic [63:0] sig;
   } fp_reg_t;

   typedef struct packed {
      logic td;
      logic wide_exponent_bit;
      logic [1:0] precision_control_field;
      logic [1:0] rc;
      logic [5:0] flags;
   } field_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } apb_rsp_t;

   localparam field_t FIELD_RESET = 12'hb00;
   localparam logic [16:0] BIAS = 17'h0ffff;
   localparam logic [17:0] TWO_BIAS = 18'h1fffe;
   localparam logic [16:0] EXP_MAX = 17'h1ffff;
   localparam logic [16:0] FAULT_SPAN = 17'h04010;
   localparam logic [16:0] SGL_BIAS = 17'h0007f;
   localparam logic [16:0] DBL_BIAS = 17'h003ff;
   localparam logic [16:0] EXT_BIAS = 17'h03fff;
   localparam logic [16:0] WIDE_LIM = 17'h0ffff;
   localparam logic [63:0] QNAN_SIG = 64'hc000_0000_0000_0000;
   localparam logic [63:0] ONE_SIG = 64'h8000_0000_0000_0000;
   localparam logic [63:0] SGL_MASK = 64'hffff_ff00_0000_0000;
   localparam logic [63:0] DBL_MASK = 64'hffff_ffff_ffff_f800;

endpackage : fp_rcp_pkg

/* verilog/fp_status_field.sv */
`timescale 1ns/1ps
module fp_status_field (
   input wire logic clk,
   input wire logic rst,
   input wire logic sw_we,
   input wire fp_rcp_pkg::field_t sw_data,
   input wire logic [5:0] set_flags,
   input wire logic clr,
   output fp_rcp_pkg::field_t field
);

   fp_rcp_pkg::field_t next_field;

   // a flag raised in the same cycle as a write or a clear still lands
   always_comb begin
      next_field = field;
      if (sw_we) begin
         next_field = sw_data;
      end else if (clr) begin
         next_field.flags = 6'h00;
      end
      next_field.flags = next_field.flags | set_flags;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         field <= fp_rcp_pkg::FIELD_RESET;
      end else begin
         field <= next_field;
      end
   end

endmodule : fp_status_field

/* verilog/fp_recip_est.sv */
`timescale 1ns/1ps
module fp_recip_est #(
   parameter int EST_BITS = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic start,
   input wire fp_rcp_pkg::fp_reg_t op_a,
   input wire fp_rcp_pkg::fp_reg_t op_b,
   output logic valid,
   output fp_rcp_pkg::fp_reg_t result,
   output logic pred,
   output logic [2:0] flags,
   output logic fault
);

   localparam int N = EST_BITS + 2;
   localparam logic [2*N-1:0] NUMER = (2*N)'(1) << (2*N-1);

   if (EST_BITS < 8 || EST_BITS > 30) begin : g_chk
      $error("estimate width out of range");
   end

   function automatic logic is_zero(fp_rcp_pkg::fp_reg_t x);
      return x.exp == 17'h00000 && x.sig == 64'h0;
   endfunction : is_zero

   function automatic logic is_nan(fp_rcp_pkg::fp_reg_t x);
      return x.exp == fp_rcp_pkg::EXP_MAX && x.sig[62:0] != 63'h0;
   endfunction : is_nan

   function automatic logic is_inf(fp_rcp_pkg::fp_reg_t x);
      return x.exp == fp_rcp_pkg::EXP_MAX && x.sig[62:0] == 63'h0;
   endfunction : is_inf

   function automatic logic far_out(fp_rcp_pkg::fp_reg_t x);
      return x.exp != fp_rcp_pkg::EXP_MAX && !is_zero(x) &&
         (x.exp < fp_rcp_pkg::BIAS - fp_rcp_pkg::FAULT_SPAN ||
          x.exp > fp_rcp_pkg::BIAS + fp_rcp_pkg::FAULT_SPAN);
   endfunction : far_out

   logic [N-1:0] mant;
   logic [2*N-1:0] quot;
   logic [17:0] rexp;
   fp_rcp_pkg::fp_reg_t next_result;
   logic next_pred;
   logic next_fault;
   logic [2:0] next_flags;
   logic spec_sign;

   // a truncated divisor and truncated quotient each lose under one ulp of N bits
   assign mant = op_b.sig[63 -: N];
   assign quot = NUMER / {{N{1'b0}}, mant};
   assign spec_sign = op_a.sign ^ op_b.sign;

   always_comb begin
      next_result = '0;
      next_pred = 1'b0;
      next_fault = 1'b0;
      next_flags = 3'h0;
      rexp = fp_rcp_pkg::TWO_BIAS - {1'b0, op_b.exp} - {17'h0, ~quot[N]};
      if (is_nan(op_a) || is_nan(op_b)) begin
         next_result = {1'b0, fp_rcp_pkg::EXP_MAX, fp_rcp_pkg::QNAN_SIG};
         next_flags[fp_rcp_pkg::FLAG_V] = (is_nan(op_a) && !op_a.sig[62]) ||
            (is_nan(op_b) && !op_b.sig[62]);
      end else if ((is_zero(op_a) && is_zero(op_b)) || (is_inf(op_a) && is_inf(op_b))) begin
         next_result = {1'b0, fp_rcp_pkg::EXP_MAX, fp_rcp_pkg::QNAN_SIG};
         next_flags[fp_rcp_pkg::FLAG_V] = 1'b1;
      end else if (is_zero(op_b) || is_inf(op_a)) begin
         next_result = {spec_sign, fp_rcp_pkg::EXP_MAX, fp_rcp_pkg::ONE_SIG};
         next_flags[fp_rcp_pkg::FLAG_Z] = is_zero(op_b);
      end else if (is_inf(op_b) || is_zero(op_a)) begin
         next_result = {spec_sign, 17'h00000, 64'h0};
      end else if (!op_a.sig[63] || !op_b.sig[63]) begin
         next_flags[fp_rcp_pkg::FLAG_D] = 1'b1;
         next_fault = 1'b1;
      end else if (far_out(op_a) || far_out(op_b)) begin
         next_fault = 1'b1;
      end else begin
         next_pred = 1'b1;
         next_result.sign = op_b.sign;
         next_result.exp = rexp[16:0];
         next_result.sig = quot[N] ? fp_rcp_pkg::ONE_SIG : {quot[N-1:0], {(64-N){1'b0}}};
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         valid <= 1'b0;
      end else begin
         valid <= start;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         result <= '0;
         pred <= 1'b0;
         flags <= 3'h0;
         fault <= 1'b0;
      end else if (start) begin
         result <= next_result;
         pred <= next_pred;
         flags <= next_flags;
         fault <= next_fault;
      end
   end

endmodule : fp_recip_est

/* tb/fp_status_fields_recip_approx_tb_top.sv */
`timescale 1ns/1ps
module fp_status_fields_recip_approx_tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   fp_rcp_pkg::apb_req_t req = '0;
   fp_rcp_pkg::apb_rsp_t rsp;
   logic irq;
   int mismatches = 0;
   int tests_run = 0;
   int cyc = 0;
   logic [31:0] seed = 32'hdf0d9a20;
   logic [31:0] x;
   fp_rcp_pkg::fp_reg_t one = {1'b0, fp_rcp_pkg::BIAS, fp_rcp_pkg::ONE_SIG};
   fp_rcp_pkg::fp_reg_t far = {1'b0, 17'h00001, fp_rcp_pkg::ONE_SIG};
   // divisor whose estimate lands below double range but inside the wide range
   fp_rcp_pkg::fp_reg_t big = {1'b0, fp_rcp_pkg::BIAS + 17'h00500, fp_rcp_pkg::ONE_SIG};
   localparam logic [31:0] RST2 = 32'h00b00b00;
   fp_status_fields_recip_approx dut_u (
      .clk(clk),
      .rst(rst),
      .apb_req(req),
      .apb_rsp(rsp),
      .irq(irq)
   );
   initial begin
      forever #2.5 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task close_out();
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : close_out
   // generous ceiling: the whole sequence needs well under a thousand cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         mismatches = mismatches + 1;
         close_out();
      end
   end
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   function automatic logic [31:0] ctl(input logic [1:0] op, sf, src);
      return {22'h0, src, 2'h0, 2'h1, sf, op};
   endfunction : ctl
   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // reads check data and error, writes check error only
   task acc(input logic w, input logic [7:0] a, input logic [31:0] d, exp, input logic xe);
      int n;
      logic [31:0] r;
      logic e;
      n = 0;
      @(posedge clk);
      req <= {1'b1, 1'b0, w, a, d};
      @(posedge clk);
      req.penable <= 1'b1;
      // pready is sampled at the rising edge; data and error are taken at that same edge
      do begin
         @(posedge clk);
         n++;
      end while (rsp.pready !== 1'b1 && n < 50);
      r = rsp.prdata;
      e = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
      if (n >= 50) mismatches++;
      if (!w) chk(r, exp);
      chk({31'h0, e}, {31'h0, xe});
   endtask : acc
   task setop(input logic [7:0] b, input fp_rcp_pkg::fp_reg_t v);
      acc(1'b1, b, v.sig[31:0], 0, 1'b0);
      acc(1'b1, b + 8'h4, v.sig[63:32], 0, 1'b0);
      acc(1'b1, b + 8'h8, {14'h0, v.sign, v.exp}, 0, 1'b0);
   endtask : setop
   task rcp(input fp_rcp_pkg::fp_reg_t a, b, input logic [1:0] sf);
      setop(fp_rcp_pkg::OPA_OFS, a);
      setop(fp_rcp_pkg::OPB_OFS, b);
      acc(1'b1, fp_rcp_pkg::CTRL_OFS, ctl(fp_rcp_pkg::OP_RECIP, sf, 2'h0), 0, 1'b0);
   endtask : rcp
   task irq_is(input logic v);
      repeat (4) @(negedge clk);
      chk({31'h0, irq}, {31'h0, v});
   endtask : irq_is
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      acc(1'b0, fp_rcp_pkg::FP_STATUS_REGISTER_LO_OFS, 0, RST2, 1'b0);
      acc(1'b0, fp_rcp_pkg::FP_STATUS_REGISTER_HI_OFS, 0, RST2, 1'b0);
      acc(1'b0, 8'hfc, 0, 0, 1'b1);
      acc(1'b1, fp_rcp_pkg::RES_OFS, 32'h1, 0, 1'b1);
      $display("test map done");
      repeat (8) begin
         x = xs() & 32'h00ffdfdf;
         acc(1'b1, fp_rcp_pkg::FP_STATUS_REGISTER_HI_OFS, x, 0, 1'b0);
         acc(1'b0, fp_rcp_pkg::FP_STATUS_REGISTER_HI_OFS, 0, x, 1'b0);
      end
      acc(1'b1, fp_rcp_pkg::FP_STATUS_REGISTER_HI_OFS, RST2, 0, 1'b0);
      $display("test fields done");
      rcp(one, '0, 2'h1);
      acc(1'b0, fp_rcp_pkg::RES_OFS + 8'h8, 0, 32'h0001ffff, 1'b0);
      acc(1'b0, fp_rcp_pkg::RSTATE_OFS, 0, 0, 1'b0);
      acc(1'b0, fp_rcp_pkg::FP_STATUS_REGISTER_LO_OFS, 0, 32'h00b04b00, 1'b0);
      rcp('0, '0, 2'h1);
      acc(1'b0, fp_rcp_pkg::FP_STATUS_REGISTER_LO_OFS, 0, 32'h00b05b00, 1'b0);
      acc(1'b1, fp_rcp_pkg::FP_STATUS_REGISTER_LO_OFS, RST2, 0, 1'b0);
      acc(1'b0, fp_rcp_pkg::FP_STATUS_REGISTER_LO_OFS, 0, RST2, 1'b0);
      rcp(one, big, 2'h1);
      acc(1'b0, fp_rcp_pkg::FP_STATUS_REGISTER_LO_OFS, 0, 32'h00b10b00, 1'b0);
      acc(1'b1, fp_rcp_pkg::FP_STATUS_REGISTER_LO_OFS, 32'h00f00b00, 0, 1'b0);
      rcp(one, big, 2'h1);
      acc(1'b0, fp_rcp_pkg::FP_STATUS_REGISTER_LO_OFS, 0, 32'h00f00b00, 1'b0);
      acc(1'b1, fp_rcp_pkg::FP_STATUS_REGISTER_LO_OFS, RST2, 0, 1'b0);
      $display("test special done");
      acc(1'b0, fp_rcp_pkg::ISTAT_OFS, 0, 1, 1'b0);
      rcp(one, far, 2'h0);
      acc(1'b0, fp_rcp_pkg::RSTATE_OFS, 0, 2, 1'b0);
      acc(1'b0, fp_rcp_pkg::ISTAT_OFS, 0, 3, 1'b0);
      $display("test assist done");
      acc(1'b1, fp_rcp_pkg::IMASK_OFS, 1, 0, 1'b0);
      rcp(one, one, 2'h0);
      irq_is(1'b1);
      acc(1'b0, fp_rcp_pkg::RSTATE_OFS, 0, 1, 1'b0);
      acc(1'b0, fp_rcp_pkg::ISTAT_OFS, 0, 1, 1'b0);
      irq_is(1'b0);
      acc(1'b1, fp_rcp_pkg::IMASK_OFS, 0, 0, 1'b0);
      rcp(one, one, 2'h0);
      irq_is(1'b0);
      $display("test irq done");
      rcp(one, '0, 2'h2);
      acc(1'b0, fp_rcp_pkg::FP_STATUS_REGISTER_HI_OFS, 0, 32'h00b00b04, 1'b0);
      acc(1'b1, fp_rcp_pkg::CTRL_OFS, ctl(fp_rcp_pkg::OP_COMMIT, 2'h0, 2'h2), 0, 1'b0);
      acc(1'b0, fp_rcp_pkg::FP_STATUS_REGISTER_LO_OFS, 0, 32'h00b00b04, 1'b0);
      acc(1'b0, fp_rcp_pkg::FP_STATUS_REGISTER_HI_OFS, 0, RST2, 1'b0);
      rcp(one, '0, 2'h3);
      acc(1'b1, fp_rcp_pkg::CTRL_OFS, ctl(fp_rcp_pkg::OP_DISCARD, 2'h3, 2'h0), 0, 1'b0);
      acc(1'b0, fp_rcp_pkg::FP_STATUS_REGISTER_HI_OFS, 0, RST2, 1'b0);
      $display("test commit done");
      acc(1'b1, fp_rcp_pkg::OPA_OFS, 32'h3f80_0000, 0, 1'b0);
      acc(1'b1, fp_rcp_pkg::CTRL_OFS, ctl(fp_rcp_pkg::OP_LOAD, 2'h0, 2'h0), 0, 1'b0);
      acc(1'b0, fp_rcp_pkg::RES_OFS + 8'h4, 0, 32'h8000_0000, 1'b0);
      acc(1'b0, fp_rcp_pkg::RES_OFS + 8'h8, 0, {15'h0, fp_rcp_pkg::BIAS}, 1'b0);
      $display("test load done");
      acc(1'b1, fp_rcp_pkg::FP_STATUS_REGISTER_LO_OFS, 32'h00b00300, 0, 1'b0);
      acc(1'b0, fp_rcp_pkg::ISTAT_OFS, 0, 1, 1'b0);
      rcp(one, '0, 2'h0);
      acc(1'b0, fp_rcp_pkg::ISTAT_OFS, 0, 5, 1'b0);
      $display("test trap done");
      close_out();
   end
endmodule : fp_status_fields_recip_approx_tb_top
